// [rtl/rfp_core.sv]
`timescale 1ns/1ps
`include "rfp_params.svh"
module rfp_core
   import rfp_pkg::*;
#(
   parameter int PHASES  = 2,
   parameter int MV_W    = 12,
   parameter int OV_CYC  = `RFP_OV_FILTER_CYC,
   parameter int UV_CYC  = `RFP_UV_FILTER_CYC,
   parameter int LO_CYC  = `RFP_LO_FILTER_CYC
) (
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire logic              controller_enable,
   input  wire logic [MV_W-1:0]   target_ref_mv,
   input  wire logic [MV_W-1:0]   rail_output_sense,
   input  wire logic              rail_output_negative,
   input  wire logic              supply_below_por,
   input  wire logic [PHASES-1:0] phase_active,
   input  wire logic [PHASES-1:0] pwm_high_req,
   input  wire logic [PHASES-1:0] pwm_low_req,
   input  wire logic              peer_fault_shutdown,
   output logic [PHASES-1:0]      gate_high,
   output logic [PHASES-1:0]      gate_low,
   output logic                   overvoltage_latch,
   output logic                   undervoltage_latch,
   output logic                   supply_lockout,
   output logic                   negative_voltage_guard,
   output logic                   peer_shutdown_req,
   output logic                   soft_shutdown
);
   localparam logic [MV_W-1:0] OV_OFS   = MV_W'(`RFP_OV_OFFSET_MV);
   localparam logic [MV_W-1:0] OV_FLOOR = MV_W'(`RFP_OV_FLOOR_MV);
   localparam logic [MV_W-1:0] UV_OFS   = MV_W'(`RFP_UV_OFFSET_MV);

   // ************************************************************
   // Comparator decode
   // ************************************************************
   logic              ov_qual;
   logic              uv_qual;
   logic              neg_qual;
   logic              lo_qual;
   logic              por_released;
   rfp_state_t        state;
   rfp_state_t        next_state;
   // Trip level uses the floor when the target is low
   wire logic [MV_W:0] ov_base  = (target_ref_mv < OV_FLOOR) ? {1'b0, OV_FLOOR}
                                                             : {1'b0, target_ref_mv};
   wire logic [MV_W:0] ov_trip  = ov_base + {1'b0, OV_OFS};
   wire logic          ov_raw   = {1'b0, rail_output_sense} > ov_trip;
   wire logic          uv_raw   = ({1'b0, rail_output_sense} + {1'b0, UV_OFS})
                                  < {1'b0, target_ref_mv};
   wire logic          monitor  = por_released & controller_enable;
   wire logic          clear    = ~controller_enable;

   // ************************************************************
   // Detector filters
   // ************************************************************
   rfp_filter #(.CYCLES(OV_CYC)) u_ov (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .raw_in   (ov_raw),
      .sync_en  (monitor),
      .qual_out (ov_qual)
   );
   rfp_filter #(.CYCLES(UV_CYC)) u_uv (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .raw_in   (uv_raw),
      .sync_en  (monitor),
      .qual_out (uv_qual)
   );
   rfp_filter #(.CYCLES(LO_CYC)) u_lo (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .raw_in   (supply_below_por),
      .sync_en  (por_released),
      .qual_out (lo_qual)
   );
   rfp_filter #(.CYCLES(1)) u_neg (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .raw_in   (rail_output_negative),
      .sync_en  (1'b1),
      .qual_out (neg_qual)
   );

   // ************************************************************
   // Fault latches
   // ************************************************************
   // Power-on release flag
   always_ff @(posedge clk_sys) begin
      if (reset) por_released <= 1'b0;
      else       por_released <= 1'b1;
   end

   // Sticky OV/UV latches, fault set wins over re-enable clear; supply lockout follows its filter
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         overvoltage_latch  <= 1'b0;
         undervoltage_latch <= 1'b0;
         supply_lockout     <= 1'b0;
      end else begin
         overvoltage_latch  <= ov_qual | (overvoltage_latch & ~clear);
         undervoltage_latch <= uv_qual | (undervoltage_latch & ~clear);
         supply_lockout     <= lo_qual;
      end
   end

   // ************************************************************
   // Protection state machine
   // ************************************************************
   always_comb begin
      next_state = state;
      case (state)
         RFP_RUN:      if (overvoltage_latch) next_state = RFP_OV_CLAMP;
         RFP_OV_CLAMP: if (neg_qual) next_state = RFP_NEG_HOLD;
         RFP_NEG_HOLD: if (!neg_qual) next_state = RFP_OV_CLAMP;
         default:      next_state = RFP_RUN;
      endcase
      if (!overvoltage_latch) next_state = RFP_RUN;
      if (supply_lockout || undervoltage_latch) next_state = RFP_ALL_OFF;
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (reset) state <= RFP_RUN;
      else       state <= next_state;
   end

   // ************************************************************
   // Gate drive
   // ************************************************************
   wire logic [PHASES-1:0] run_high  = pwm_high_req & phase_active & {PHASES{~soft_shutdown}};
   wire logic [PHASES-1:0] run_low   = pwm_low_req & phase_active & {PHASES{~soft_shutdown}};
   wire logic              sel_run   = (state == RFP_RUN);
   wire logic              sel_clamp = (state == RFP_OV_CLAMP);
   wire logic [PHASES-1:0] next_high = sel_run ? run_high : '0;
   wire logic [PHASES-1:0] next_low  = sel_run ? run_low
                                     : (sel_clamp ? phase_active : '0);

   // Registered gate outputs
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         gate_high              <= '0;
         gate_low               <= '0;
         negative_voltage_guard <= 1'b0;
         peer_shutdown_req      <= 1'b0;
         soft_shutdown          <= 1'b0;
      end else begin
         gate_high              <= next_high;
         gate_low               <= next_low;
         negative_voltage_guard <= (next_state == RFP_NEG_HOLD);
         peer_shutdown_req      <= overvoltage_latch | undervoltage_latch;
         soft_shutdown          <= peer_fault_shutdown | (soft_shutdown & ~clear);
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   property p_ov_clamp;
      @(posedge clk_sys) disable iff (reset)
      (state == RFP_OV_CLAMP) |=> (gate_high == '0) && (gate_low == $past(phase_active));
   endproperty
   a_ov_clamp: assert property (p_ov_clamp) else $error("clamp drive wrong");

   property p_peer;
      @(posedge clk_sys) disable iff (reset)
      $rose(overvoltage_latch | undervoltage_latch) |=> peer_shutdown_req;
   endproperty
   a_peer: assert property (p_peer) else $error("peer shutdown missing");

   // Consecutive over-voltage cycles, saturating, for the filter check
   logic [`RFP_CNT_W-1:0] ov_run;
   always_ff @(posedge clk_sys) begin
      if (reset || !ov_raw)  ov_run <= 12'h000;
      else if (ov_run != '1) ov_run <= ov_run + 12'h001;
   end

   property p_ov_filter;
      @(posedge clk_sys) disable iff (reset)
      $rose(overvoltage_latch) |-> ($past(ov_run, 3) >= OV_CYC);
   endproperty
   a_ov_filter: assert property (p_ov_filter) else $error("ov latched unfiltered");

   property p_neg_off;
      @(posedge clk_sys) disable iff (reset)
      (state == RFP_NEG_HOLD) |=> (gate_low == '0) && (gate_high == '0);
   endproperty
   a_neg_off: assert property (p_neg_off) else $error("neg hold drives");

   property p_neg_gated;
      @(posedge clk_sys) disable iff (reset)
      negative_voltage_guard |-> $past(overvoltage_latch);
   endproperty
   a_neg_gated: assert property (p_neg_gated) else $error("guard without ov");

   property p_uv_off;
      @(posedge clk_sys) disable iff (reset)
      undervoltage_latch |=> ##1 (gate_high == '0) && (gate_low == '0);
   endproperty
   a_uv_off: assert property (p_uv_off) else $error("uv drives");

   property p_lock_off;
      @(posedge clk_sys) disable iff (reset)
      supply_lockout |=> ##1 (gate_high == '0) && (gate_low == '0);
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("lockout drives");

   property p_sticky;
      @(posedge clk_sys) disable iff (reset)
      (undervoltage_latch && controller_enable) |=> undervoltage_latch;
   endproperty
   a_sticky: assert property (p_sticky) else $error("uv latch released");
endmodule

// [rtl/rfp_params.svh]
`ifndef RFP_PARAMS_SVH
`define RFP_PARAMS_SVH
// Filter delays in ns
`define RFP_CLK_PERIOD_NS 10
`define RFP_OV_FILTER_NS  1000
`define RFP_UV_FILTER_NS  3000
`define RFP_LO_FILTER_NS  3000
// Filter delays in cycles, rounded up
`define RFP_OV_FILTER_CYC ((`RFP_OV_FILTER_NS + `RFP_CLK_PERIOD_NS - 1) / `RFP_CLK_PERIOD_NS)
`define RFP_UV_FILTER_CYC ((`RFP_UV_FILTER_NS + `RFP_CLK_PERIOD_NS - 1) / `RFP_CLK_PERIOD_NS)
`define RFP_LO_FILTER_CYC ((`RFP_LO_FILTER_NS + `RFP_CLK_PERIOD_NS - 1) / `RFP_CLK_PERIOD_NS)
// Trip offsets and floor, in mV
`define RFP_OV_OFFSET_MV  325
`define RFP_OV_FLOOR_MV   900
`define RFP_UV_OFFSET_MV  500
`define RFP_CNT_W         12
`endif

// [rtl/rfp_pkg.sv]
package rfp_pkg;
   typedef enum logic [1:0] {
      RFP_RUN      = 2'b00,
      RFP_OV_CLAMP = 2'b01,
      RFP_NEG_HOLD = 2'b10,
      RFP_ALL_OFF  = 2'b11
   } rfp_state_t;
endpackage

// [rtl/rfp_filter.sv]
`timescale 1ns/1ps
`include "rfp_params.svh"
module rfp_filter #(
   parameter int CYCLES = 100
) (
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic raw_in,
   input  wire logic sync_en,
   output logic      qual_out
);
   logic [2:0]           sync;
   logic [`RFP_CNT_W-1:0] count;
   wire logic            stable_high = sync[1] & sync[2];
   wire logic            done = (count == CYCLES[`RFP_CNT_W-1:0] - 12'h001);

   // Three-stage synchroniser
   always_ff @(posedge clk_sys) begin
      if (reset) sync <= 3'h0;
      else       sync <= {sync[1:0], raw_in};
   end

   // Persistence counter, qualifies after CYCLES agreed-high cycles
   always_ff @(posedge clk_sys) begin
      if (reset || !stable_high || !sync_en) begin
         count    <= 12'h000;
         qual_out <= 1'b0;
      end else if (done) begin
         qual_out <= 1'b1;
      end else begin
         count <= count + 12'h001;
      end
   end
endmodule

// [dv/rfp_rail_model.sv]
`timescale 1ns/1ps
// ****************************************
// Gate driver and rail load model
// ****************************************
module rfp_rail_model #(
   parameter int PHASES = 2
) (
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire logic              neg_cmd,
   input  wire logic [PHASES-1:0] gate_high,
   input  wire logic [PHASES-1:0] gate_low,
   output logic                   rail_output_negative,
   output logic                   shoot_through
);
   // Rail dips below 0 V only once low-sides have dragged it there
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rail_output_negative <= 1'b0;
         shoot_through        <= 1'b0;
      end else begin
         rail_output_negative <= neg_cmd & (rail_output_negative | (|gate_low));
         shoot_through        <= shoot_through | (|(gate_high & gate_low));
      end
   end
endmodule

// [dv/rail_fault_protection_tb.sv]
`timescale 1ns/1ps
// ****************************************
// Fault sequencing bench
// ****************************************
module rail_fault_protection_tb;
   import rfp_pkg::*;
   logic        clk_sys = 1'b0;
   logic        reset, en, neg_cmd, sup_low, peer_in;
   logic [11:0] ref_mv, sense;
   logic [1:0]  act, ph, pl, gh, gl;
   logic        ov, uv, lo, guard, psr, ssd, neg, st;
   int          fails = 0;
   int          tests_run = 0;

   // Clock and parts
   always #5 clk_sys = ~clk_sys;
   rfp_core #(.PHASES(2), .OV_CYC(4), .UV_CYC(4), .LO_CYC(4)) dut_u (
      .clk_sys(clk_sys), .reset(reset), .controller_enable(en), .target_ref_mv(ref_mv),
      .rail_output_sense(sense), .rail_output_negative(neg), .supply_below_por(sup_low),
      .phase_active(act), .pwm_high_req(ph), .pwm_low_req(pl),
      .peer_fault_shutdown(peer_in), .gate_high(gh), .gate_low(gl),
      .overvoltage_latch(ov), .undervoltage_latch(uv), .supply_lockout(lo),
      .negative_voltage_guard(guard), .peer_shutdown_req(psr), .soft_shutdown(ssd));
   rfp_rail_model #(.PHASES(2)) load_u (
      .clk_sys(clk_sys), .reset(reset), .neg_cmd(neg_cmd), .gate_high(gh),
      .gate_low(gl), .rail_output_negative(neg), .shoot_through(st));

   task automatic chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Re-enable clears latches, inputs back to nominal
   task automatic clr();
      en <= 1'b0; ref_mv <= 12'h3E8; sense <= 12'h3E8; neg_cmd <= 1'b0; sup_low <= 1'b0;
      ph <= 2'h0; pl <= 2'h3; act <= 2'h3;
      cyc(3);
      en <= 1'b1;
      cyc(10);
   endtask

   task automatic t_ov();
      clr(); act <= 2'h1; sense <= 12'h528; cyc(20);
      chk("ov below trip", 2'(ov), 2'h0);
      sense <= 12'h578; cyc(2); sense <= 12'h3E8; cyc(20);
      chk("ov glitch", 2'(ov), 2'h0);
      sense <= 12'h578; cyc(20);
      chk("ov latch", 2'(ov), 2'h1);
      chk("ov low", gl, 2'h1);
      chk("ov high", gh, 2'h0);
      chk("ov peer", 2'(psr), 2'h1);
      sense <= 12'h3E8; cyc(20);
      chk("ov held", 2'(ov), 2'h1);
      neg_cmd <= 1'b1; cyc(10);
      chk("nv low", gl, 2'h0);
      chk("nv high", gh, 2'h0);
      chk("nv guard", 2'(guard), 2'h1);
      neg_cmd <= 1'b0; cyc(10);
      chk("nv resume", gl, 2'h1);
      chk("nv guard off", 2'(guard), 2'h0);
   endtask

   task automatic t_floor();
      clr(); ref_mv <= 12'h1F4; sense <= 12'h4B0; cyc(20);
      chk("floor no trip", 2'(ov), 2'h0);
      sense <= 12'h4CE; cyc(20);
      chk("floor trip", 2'(ov), 2'h1);
   endtask

   task automatic t_nv_gate();
      clr(); neg_cmd <= 1'b1; cyc(10);
      chk("nv ignored", 2'(guard), 2'h0);
      chk("nv low kept", gl, 2'h3);
   endtask

   task automatic t_uv();
      clr(); sense <= 12'h258; cyc(20);
      chk("uv above", 2'(uv), 2'h0);
      sense <= 12'h190; cyc(2); sense <= 12'h3E8; cyc(20);
      chk("uv glitch", 2'(uv), 2'h0);
      sense <= 12'h190; cyc(20);
      chk("uv latch", 2'(uv), 2'h1);
      chk("uv low", gl, 2'h0);
      chk("uv high", gh, 2'h0);
      chk("uv peer", 2'(psr), 2'h1);
      sense <= 12'h3E8; cyc(10);
      chk("uv held", 2'(uv), 2'h1);
   endtask

   task automatic t_lo();
      clr(); ph <= 2'h3; pl <= 2'h0; sup_low <= 1'b1; cyc(2); sup_low <= 1'b0; cyc(20);
      chk("lockout glitch", 2'(lo), 2'h0);
      sup_low <= 1'b1; cyc(20);
      chk("lockout", 2'(lo), 2'h1);
      chk("lockout high", gh, 2'h0);
      chk("lockout low", gl, 2'h0);
      sup_low <= 1'b0; cyc(20);
      chk("lockout gone", 2'(lo), 2'h0);
   endtask

   // Other rail fault starts soft shutdown here, re-enable releases it
   task automatic t_peer();
      clr(); peer_in <= 1'b1; cyc(2); peer_in <= 1'b0; cyc(5);
      chk("peer soft off", 2'(ssd), 2'h1);
      chk("peer low off", gl, 2'h0);
      chk("peer high off", gh, 2'h0);
      clr();
      chk("peer released", 2'(ssd), 2'h0);
      chk("peer low back", gl, 2'h3);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      reset = 1'b1; en = 1'b0; ref_mv = 12'h3E8; sense = 12'h3E8; neg_cmd = 1'b0;
      sup_low = 1'b0; peer_in = 1'b0; act = 2'h3; ph = 2'h0; pl = 2'h3;
      cyc(10);
      reset <= 1'b0;
      t_ov();
      t_floor();
      t_nv_gate();
      t_uv();
      t_lo();
      t_peer();
      chk("no shoot-through", 2'(st), 2'h0);
      give_verdict();
   end

   // Watchdog well past the expected run
   initial begin
      cyc(20000);
      fails++;
      give_verdict();
   end
endmodule
